// file: fan_motor_drive_control.sv
// Commutation, speed gating, lock protection and tachometer for a fan drive.
// Notes on behaviour
// (RL1) Locked rotor switches both bridge outputs off.
// (RL2) Drive restarts itself after the off interval.
// (RL3) Internal timer measures lock on/off intervals.
// (RL4) Tachometer output reflects rotor rotation.
// (RL5) Speed input gates the coil drive.
// (RL6) Controller drives speed input at 200 Hz minimum.
// (RL7) Floating speed input means full speed.
// (RL8) Low duty still gives some on-torque.
// (RL9) Zero duty stops drive, enters standby.
// (RL10) Over-temperature disables the bridge drivers.
// (RL11) Lock on-attempt lasts 0.4 s.
// (RL12) Lock off phase lasts 3.0 s.
// (RL13) Running-to-lock hold is one on-period.
// (RL14) Lock declared without polarity change; cleared on change.
// (RL15) Tachometer follows polarity, holds during shutdown.
`timescale 1ns/10ps
`default_nettype none
module fan_motor_drive_control
    import fan_drive_pkg::*;
#(
    parameter logic [TMR_W-1:0]  ON_CYCLES   = T_ON_CYC,
    parameter logic [TMR_W-1:0]  OFF_CYCLES  = T_OFF_CYC,
    parameter logic [STBY_W-1:0] STBY_CYCLES = STBY_CYC
) (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic srst,
    // Sensor and protection inputs
    input  wire logic hallNorth,
    input  wire logic overtempShutdown,
    // Speed control pin
    input  wire logic pwmIn,
    input  wire logic pwmFloat,
    // Bridge outputs
    output logic      drvEnable,
    output logic      drvOut1,
    output logic      drvOut2,
    // Status
    output logic      standbyMode,
    // Tachometer, open drain
    output logic      speedPulseOut,
    output logic      speedPulseOe
);
    // ------------------------------------------------------------
    // Speed input conditioning
    // ------------------------------------------------------------
    logic                pwmEff;
    logic                pwmPrev_ff, nxt_pwmPrev;
    logic [STBY_W-1:0]   lowCnt_ff, nxt_lowCnt;
    logic                standby_ff, nxt_standby;
    logic [MINON_W-1:0]  stretch_ff, nxt_stretch;
    logic                gateOn;

    assign pwmEff = pwmFloat | pwmIn; // see RL7
    assign gateOn = pwmEff | (stretch_ff != '0); // see RL8

    always_comb begin
        nxt_pwmPrev = pwmEff;
        nxt_lowCnt  = lowCnt_ff;
        nxt_standby = standby_ff;
        nxt_stretch = stretch_ff;
        if (pwmEff) begin
            nxt_lowCnt  = '0;
            nxt_standby = 1'b0;
        end else if (lowCnt_ff != STBY_CYCLES) begin
            nxt_lowCnt = lowCnt_ff + STBY_W'(1);
        end else begin
            nxt_standby = 1'b1; // see RL9
        end
        // A short pulse is widened so a very low duty still turns the rotor.
        if (pwmEff && !pwmPrev_ff) begin
            nxt_stretch = MINON_CYC - MINON_W'(1); // see RL8
        end else if (stretch_ff != '0) begin
            nxt_stretch = stretch_ff - MINON_W'(1);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pwmPrev_ff <= 1'b0;
            lowCnt_ff  <= '0;
            standby_ff <= 1'b0;
            stretch_ff <= '0;
        end else begin
            pwmPrev_ff <= nxt_pwmPrev;
            lowCnt_ff  <= nxt_lowCnt;
            standby_ff <= nxt_standby;
            stretch_ff <= nxt_stretch;
        end
    end

    // ------------------------------------------------------------
    // Locked-rotor state machine
    // ------------------------------------------------------------
    lock_state_t        state_ff, nxt_state;
    logic               hallPrev_ff, nxt_hallPrev;
    logic               hallEdge;
    logic               hold;
    logic               tmrLoad;
    logic [TMR_W-1:0]   tmrLoadVal;
    logic [TMR_W-1:0]   tmrCount;
    logic               expired;

    assign hallEdge = hallNorth != hallPrev_ff;
    assign hold     = standby_ff | overtempShutdown;
    assign expired  = tmrCount == '0;

    lock_interval_timer u_timer ( // see RL3
        .sys_clk (sys_clk),
        .load    (tmrLoad),
        .loadVal (tmrLoadVal),
        .count   (tmrCount)
    );

    always_comb begin
        nxt_state    = state_ff;
        nxt_hallPrev = hallNorth;
        tmrLoad      = srst;
        tmrLoadVal   = ON_CYCLES;
        unique case (state_ff)
            ST_RUN: begin
                // No lock is judged while the drive is held off on purpose.
                if (hallEdge || hold) begin
                    tmrLoad = 1'b1; // see RL14
                end else if (expired) begin
                    nxt_state = ST_LOCK_ON; // see RL13
                    tmrLoad   = 1'b1;
                end
            end
            ST_LOCK_ON: begin
                if (hallEdge || hold) begin
                    nxt_state = ST_RUN; // see RL14
                    tmrLoad   = 1'b1;
                end else if (expired) begin
                    nxt_state  = ST_LOCK_OFF; // see RL1
                    tmrLoad    = 1'b1;
                    tmrLoadVal = OFF_CYCLES; // see RL12
                end
            end
            ST_LOCK_OFF: begin
                if (hallEdge) begin
                    nxt_state = ST_RUN; // see RL14
                    tmrLoad   = 1'b1;
                end else if (expired) begin
                    nxt_state = ST_LOCK_ON; // see RL2
                    tmrLoad   = 1'b1; // see RL11
                end
            end
            default: begin
                nxt_state = ST_RUN;
                tmrLoad   = 1'b1;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_ff    <= ST_RUN;
            hallPrev_ff <= 1'b0;
        end else begin
            state_ff    <= nxt_state;
            hallPrev_ff <= nxt_hallPrev;
        end
    end

    // ------------------------------------------------------------
    // Bridge and tachometer outputs
    // ------------------------------------------------------------
    logic driveOn;
    logic drvEnable_ff, nxt_drvEnable;
    logic drvOut1_ff, nxt_drvOut1;
    logic drvOut2_ff, nxt_drvOut2;
    logic tach_ff, nxt_tach;

    assign driveOn = gateOn && !standby_ff && !overtempShutdown // see RL5
                     && (state_ff != ST_LOCK_OFF); // see RL1

    always_comb begin
        nxt_drvEnable = driveOn; // see RL10
        nxt_drvOut1   = driveOn && !hallNorth;
        nxt_drvOut2   = driveOn && hallNorth;
        nxt_tach      = tach_ff;
        // The tachometer freezes during the lock off phase and over-temperature; it keeps following in standby.
        if (state_ff != ST_LOCK_OFF && !overtempShutdown) begin
            nxt_tach = hallNorth; // see RL4 RL15
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            drvEnable_ff <= 1'b0;
            drvOut1_ff   <= 1'b0;
            drvOut2_ff   <= 1'b0;
            tach_ff      <= 1'b0;
        end else begin
            drvEnable_ff <= nxt_drvEnable;
            drvOut1_ff   <= nxt_drvOut1;
            drvOut2_ff   <= nxt_drvOut2;
            tach_ff      <= nxt_tach;
        end
    end

    assign drvEnable     = drvEnable_ff;
    assign drvOut1       = drvOut1_ff;
    assign drvOut2       = drvOut2_ff;
    assign standbyMode   = standby_ff;
    assign speedPulseOut = 1'b0;
    assign speedPulseOe  = !tach_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence enterOff;
        (state_ff != ST_LOCK_OFF) ##1 (state_ff == ST_LOCK_OFF);
    endsequence

    sequence enterOnFromRun;
        (state_ff == ST_RUN) ##1 (state_ff == ST_LOCK_ON);
    endsequence

    sequence pwmRise;
        !pwmEff ##1 pwmEff;
    endsequence

    chk_off_no_drive: assert property (@(posedge sys_clk) disable iff (srst) // see RL1
        (state_ff == ST_LOCK_OFF) |=> (!drvEnable && !drvOut1 && !drvOut2))
        else $error("bridge driven during lock off phase");

    chk_auto_restart: assert property (@(posedge sys_clk) disable iff (srst) // see RL2
        (state_ff == ST_LOCK_OFF && expired && !hallEdge) |=> (state_ff == ST_LOCK_ON))
        else $error("no restart after off interval");

    chk_off_interval: assert property (@(posedge sys_clk) disable iff (srst) // see RL12
        enterOff |-> (tmrCount == OFF_CYCLES))
        else $error("off interval not loaded");

    chk_first_hold: assert property (@(posedge sys_clk) disable iff (srst) // see RL13
        enterOnFromRun |-> (tmrCount == ON_CYCLES))
        else $error("lock on period not loaded");

    chk_timer_rearm: assert property (@(posedge sys_clk) disable iff (srst) // see RL3
        (state_ff == ST_RUN && hallEdge) |=> (tmrCount == ON_CYCLES && state_ff == ST_RUN))
        else $error("timer not rearmed on polarity change");

    chk_lock_clear: assert property (@(posedge sys_clk) disable iff (srst) // see RL14
        (state_ff != ST_RUN && hallEdge) |=> (state_ff == ST_RUN))
        else $error("lock not cleared on polarity change");

    chk_pwm_gate: assert property (@(posedge sys_clk) disable iff (srst) // see RL5
        (state_ff == ST_RUN && !standby_ff && !overtempShutdown) |=> (drvEnable == $past(gateOn)))
        else $error("drive does not follow speed input");

    chk_float_full: assert property (@(posedge sys_clk) disable iff (srst) // see RL7
        (pwmFloat && state_ff == ST_RUN && !overtempShutdown)
        ##1 (pwmFloat && !overtempShutdown) |=> drvEnable)
        else $error("floating input does not give full drive");

    chk_min_torque: assert property (@(posedge sys_clk) disable iff (srst) // see RL8
        pwmRise |=> gateOn [*8])
        else $error("short pulse not widened");

    chk_standby_off: assert property (@(posedge sys_clk) disable iff (srst) // see RL9
        (!pwmEff && lowCnt_ff == STBY_CYCLES) |=> standby_ff ##1 !drvEnable)
        else $error("zero duty does not enter standby");

    chk_overtemp_off: assert property (@(posedge sys_clk) disable iff (srst) // see RL10
        overtempShutdown |=> !drvEnable)
        else $error("bridge driven during over-temperature");

    chk_tach_follow: assert property (@(posedge sys_clk) disable iff (srst) // see RL15
        (state_ff != ST_LOCK_OFF && !overtempShutdown) |=> (speedPulseOe == !$past(hallNorth)))
        else $error("tachometer does not follow polarity");

    chk_tach_hold: assert property (@(posedge sys_clk) disable iff (srst) // see RL15
        (state_ff == ST_LOCK_OFF) ##1 (state_ff == ST_LOCK_OFF) |-> $stable(speedPulseOe))
        else $error("tachometer moved during shutdown");
endmodule
`default_nettype wire

// file: fan_drive_pkg.sv
// Shared constants for the fan motor drive control logic.
`default_nettype none
package fan_drive_pkg;

    // ------------------------------------------------------------
    // Clock
    // ------------------------------------------------------------
    localparam int CLK_KHZ = 40_000;

    // ------------------------------------------------------------
    // Locked-rotor timing
    // ------------------------------------------------------------
    localparam int TMR_W    = 27;
    localparam int T_ON_MS  = 400;
    localparam int T_OFF_MS = 3000;
    localparam logic [TMR_W-1:0] T_ON_CYC  = TMR_W'(T_ON_MS * CLK_KHZ);
    localparam logic [TMR_W-1:0] T_OFF_CYC = TMR_W'(T_OFF_MS * CLK_KHZ);

    // ------------------------------------------------------------
    // Speed input handling
    // ------------------------------------------------------------
    // Held low longer than one period of the slowest legal input means 0 % duty.
    localparam int STBY_W   = 18;
    localparam int T_STBY_US = 5000;
    localparam logic [STBY_W-1:0] STBY_CYC = STBY_W'(T_STBY_US * CLK_KHZ / 1000);
    // Least on-time applied per input pulse, 20 % of a 25 kHz period.
    localparam int MINON_W   = 9;
    localparam int T_MINON_NS = 8000;
    localparam logic [MINON_W-1:0] MINON_CYC =
        MINON_W'((T_MINON_NS * (CLK_KHZ / 1000) + 999) / 1000);

    // ------------------------------------------------------------
    // Lock state machine
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_RUN     = 2'b00,
        ST_LOCK_ON = 2'b01,
        ST_LOCK_OFF = 2'b10
    } lock_state_t;

endpackage
`default_nettype wire

// file: lock_interval_timer.sv
// Loadable down-counter that measures the locked-rotor intervals.
`timescale 1ns/10ps
`default_nettype none
module lock_interval_timer
    import fan_drive_pkg::*;
(
    // Clock
    input  wire logic             sys_clk,
    // Control
    input  wire logic             load,
    input  wire logic [TMR_W-1:0] loadVal,
    // State
    output logic      [TMR_W-1:0] count
);
    logic [TMR_W-1:0] count_ff;
    logic [TMR_W-1:0] nxt_count;

    // Reset is applied by the owner through load, so no reset port is needed here.
    always_comb begin
        nxt_count = count_ff;
        if (load) begin
            nxt_count = loadVal;
        end else if (count_ff != '0) begin
            nxt_count = count_ff - TMR_W'(1);
        end
    end

    always_ff @(posedge sys_clk) begin
        count_ff <= nxt_count;
    end

    assign count = count_ff;
endmodule
`default_nettype wire

// file: fan_host_model.sv
// Behavioural model of the fan system controller on the speed and tachometer pins.
`timescale 1ns/10ps
`default_nettype none
module fan_host_model (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        srst,
    // Pattern control
    input  wire logic        runPwm,
    input  wire logic        floatPin,
    input  wire logic [15:0] highCyc,
    input  wire logic [15:0] lowCyc,
    // Tachometer pin, open drain
    input  wire logic        pinData,
    input  wire logic        pinOe,
    // Speed pin and readout
    output logic             pwmIn,
    output logic             pwmFloat,
    output logic             tachLevel,
    output logic [15:0]      tachEdges
);
    logic [15:0] phase_ff;
    logic        tachPrev_ff;

    // The pull-up sets the tachometer level whenever the device releases the pin.
    assign tachLevel = pinOe ? pinData : 1'b1;
    assign pwmFloat  = floatPin;

    // Each period starts with its high phase, so a one-cycle high is still a pulse.
    always_ff @(posedge sys_clk) begin
        if (srst || !runPwm) begin
            phase_ff <= 16'h0;
            pwmIn    <= 1'b0;
        end else begin
            pwmIn    <= (phase_ff < highCyc);
            phase_ff <= (phase_ff + 16'h1 >= highCyc + lowCyc) ? 16'h0 : phase_ff + 16'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        tachPrev_ff <= tachLevel;
        if (srst) begin
            tachEdges <= 16'h0;
        end else if (tachLevel != tachPrev_ff) begin
            tachEdges <= tachEdges + 16'h1;
        end
    end
endmodule
`default_nettype wire

// file: fan_motor_drive_control_tb_top.sv
// Self-checking testbench for the fan motor drive control block.
`timescale 1ns/10ps
`default_nettype none
module fan_motor_drive_control_tb_top
    import fan_drive_pkg::*;
;
    localparam int ON  = 20;
    localparam int OFF = 160;
    localparam int STB = 400;

    logic        sys_clk = 1'b0;
    logic        srst = 1'b1;
    logic        hallNorth;
    logic        hallBase = 1'b0;
    logic        hallSpin = 1'b0;
    logic        overtempShutdown = 1'b0;
    logic        runPwm = 1'b0;
    logic        floatPin = 1'b0;
    logic [15:0] highCyc = 16'h0;
    logic [15:0] lowCyc = 16'h0;
    logic        hallRun = 1'b0;
    logic [2:0]  hallCnt = 3'h0;
    logic        pwmIn, pwmFloat, drvEnable, drvOut1, drvOut2, standbyMode;
    logic        speedPulseOut, speedPulseOe, tachLevel;
    logic [15:0] tachEdges;
    int          err_count = 0;
    int          tests_run = 0;

    always #12.5 sys_clk = ~sys_clk;

    // Keeps the rotor turning so that no lock is seen while other features are tested.
    always @(posedge sys_clk) begin
        if (hallRun) begin
            hallCnt <= hallCnt + 3'h1;
            if (hallCnt == 3'h7) begin
                hallSpin <= ~hallSpin;
            end
        end
    end

    // Scenario steps and the background rotation each own one half of the polarity.
    assign hallNorth = hallBase ^ hallSpin;

    fan_motor_drive_control #(
        .ON_CYCLES  (TMR_W'(ON)),
        .OFF_CYCLES (TMR_W'(OFF)),
        .STBY_CYCLES(STBY_W'(STB))
    ) fan_motor_drive_control_inst (
        .sys_clk(sys_clk), .srst(srst), .hallNorth(hallNorth),
        .overtempShutdown(overtempShutdown), .pwmIn(pwmIn), .pwmFloat(pwmFloat),
        .drvEnable(drvEnable), .drvOut1(drvOut1), .drvOut2(drvOut2),
        .standbyMode(standbyMode), .speedPulseOut(speedPulseOut),
        .speedPulseOe(speedPulseOe)
    );

    fan_host_model fan_host_model_inst (
        .sys_clk(sys_clk), .srst(srst), .runPwm(runPwm), .floatPin(floatPin),
        .highCyc(highCyc), .lowCyc(lowCyc), .pinData(speedPulseOut),
        .pinOe(speedPulseOe), .pwmIn(pwmIn), .pwmFloat(pwmFloat),
        .tachLevel(tachLevel), .tachEdges(tachEdges)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask

    task automatic run_len(input logic lvl, output int n);
        n = 0;
        while (drvEnable === lvl && n < 1000) begin
            cyc(1);
            n++;
        end
    endtask

    task automatic complete_run;
        $display("Checks: %0d, mismatches: %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_full_speed;
        logic [15:0] e0;
        @(posedge sys_clk);
        floatPin <= 1'b1;
        cyc(3);
        chk(drvEnable, 1'b1);
        chk({drvOut1, drvOut2}, 2'b10);
        chk(tachLevel, 1'b0);
        e0 = tachEdges;
        @(posedge sys_clk);
        hallBase <= 1'b1;
        cyc(3);
        chk({drvOut1, drvOut2}, 2'b01);
        chk(tachLevel, 1'b1);
        chk(tachEdges - e0, 16'h1);
    endtask

    task automatic test_lock;
        int n1, n2, n3;
        logic t0;
        @(posedge sys_clk);
        hallBase <= ~hallBase;
        cyc(1);
        run_len(1'b1, n1);
        // Two intervals of ON+1 cycles each, plus the output register.
        chk(n1 >= ON && n1 <= 2 * ON + 3, 1'b1);
        chk({drvOut1, drvOut2}, 2'b00);
        t0 = tachLevel;
        run_len(1'b0, n2);
        chk(n2 >= OFF - 2 && n2 <= OFF + 2, 1'b1);
        chk(tachLevel, t0);
        run_len(1'b1, n3);
        chk(n3 >= ON - 2 && n3 <= ON + 2, 1'b1);
        chk(n2 >= 7 * n3, 1'b1);
        @(posedge sys_clk);
        hallBase <= ~hallBase;
        cyc(3);
        chk(drvEnable, 1'b1);
        hallRun <= 1'b1;
        cyc(30);
        chk(drvEnable, 1'b1);
    endtask

    task automatic test_overtemp;
        logic t0;
        @(posedge sys_clk);
        overtempShutdown <= 1'b1;
        cyc(2);
        chk(drvEnable, 1'b0);
        t0 = tachLevel;
        cyc(30);
        chk(drvEnable, 1'b0);
        chk(tachLevel, t0);
        @(posedge sys_clk);
        overtempShutdown <= 1'b0;
        cyc(3);
        chk(drvEnable, 1'b1);
    endtask

    task automatic test_speed_input;
        @(posedge sys_clk);
        floatPin <= 1'b0;
        cyc(STB + 10);
        chk({standbyMode, drvEnable}, 2'b10);
        // A single one-cycle pulse: the lowest duty that is still not zero.
        @(posedge sys_clk);
        highCyc <= 16'h1;
        lowCyc  <= 16'h07D0;
        runPwm  <= 1'b1;
        cyc(100);
        chk({standbyMode, drvEnable}, 2'b01);
        cyc(260);
        chk({standbyMode, drvEnable}, 2'b00);
        cyc(60);
        chk(standbyMode, 1'b1);
        @(posedge sys_clk);
        floatPin <= 1'b1;
        cyc(4);
        chk({standbyMode, drvEnable}, 2'b01);
    endtask

    initial begin
        repeat (5000) @(posedge sys_clk);
        err_count++;
        complete_run;
    end

    initial begin
        cyc(11);
        chk({drvEnable, standbyMode, tachLevel}, 3'b000);
        @(posedge sys_clk);
        srst <= 1'b0;
        cyc(1);
        test_full_speed();
        test_lock();
        test_overtemp();
        test_speed_input();
        complete_run;
    end
endmodule
`default_nettype wire
